// ---- core/ddsl_pkg.sv ----
package ddsl_pkg;
    localparam int          CLK_HZ            = 100_000_000;
    localparam int          NCH               = 8;
    // Times in their own units.
    localparam int          BLANK_MS          = 2;
    localparam int          GATE_HOLD_MS      = 100;
    localparam int          SCAN_HZ           = 1000;
    localparam int          SPUR_CLEAR_MS     = 4;
    localparam int          ROWS              = 3;
    // Derived cycle counts.
    localparam int          BLANK_CYC         = CLK_HZ / 1000 * BLANK_MS;
    localparam int          GATE_HOLD_CYC     = CLK_HZ / 1000 * GATE_HOLD_MS;
    localparam int          ROW_CYC           = CLK_HZ / SCAN_HZ / ROWS;
    localparam int          SPUR_CYC          = CLK_HZ / 1000 * SPUR_CLEAR_MS;
    // Register map.
    localparam logic [7:0]  ADDR_OUT_CMD      = 8'h00;
    localparam logic [7:0]  ADDR_GLOBAL_FAULT = 8'h04;
    localparam logic [7:0]  ADDR_LINK_FAULT   = 8'h08;
    localparam logic [7:0]  ADDR_CH_STATUS    = 8'h0C;
    localparam logic [7:0]  ADDR_STRAPS       = 8'h10;
    localparam logic [7:0]  ADDR_DIAG_RAW     = 8'h14;
    localparam logic [7:0]  ADDR_DIAG_SC      = 8'h18;
    localparam logic [7:0]  ADDR_DIAG_OLOFF   = 8'h1C;
    // Global fault bits.
    localparam int          GF_LOW            = 0;
    localparam int          GF_MISS           = 1;
    localparam int          GF_OTP            = 2;
    localparam int          GF_OFF            = 3;
    localparam int          GF_LAMP           = 4;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
    localparam logic [31:0] ZERO32            = 32'h0000_0000;

    typedef struct packed {
        logic low_supply;
        logic supply_missing;
        logic die_hot;
    } ddsl_mon_type;

    typedef struct packed {
        logic [NCH-1:0] thermal;
        logic [NCH-1:0] current_limit;
        logic [NCH-1:0] cold_lamp;
        logic [NCH-1:0] short_raw;
        logic [NCH-1:0] open_off_raw;
        logic [NCH-1:0] open_on_raw;
    } ddsl_chan_type;

    typedef enum logic [1:0] {
        DDSL_LOCK = 2'b00,
        DDSL_CFG  = 2'b01,
        DDSL_RUN  = 2'b10
    } ddsl_state_type;
endpackage : ddsl_pkg

// ---- core/ddsl_top.sv ----
// Contract
// - Low supply flag below 16 V.
// - Missing supply flag below 13 V.
// - Die hot flag, no shutdown.
// - All-off flag when drivers all off.
// - Cold-load flag on any channel.
// - Lockout: registers reset, flags high.
// - Straps sampled after lockout.
// - Blank supply comparators about 2 ms.
// - Low supply sets bit, outputs continue.
// - Missing supply sets its bit.
// - Fault pin freed by host read.
// - Hot channel restarts after cooling.
// - Indicator is command AND gate.
// - Gate low 100 ms after fault.
// - 3x3 matrix, rows one third at 1 kHz.
// - Lit only when active and fault free.
// - Spurious open-off gone within 4 ms; here oloff_rep passes it through unmasked and leaves it to software.
// - Short reported with open-on.
// - Wire break reports short.
// - Short outranks open-off.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module ddsl_top
    import ddsl_pkg::*;
#(
    parameter int BLANK_CYCLES = BLANK_CYC,
    parameter int HOLD_CYCLES  = GATE_HOLD_CYC,
    parameter int ROW_CYCLES   = ROW_CYC,
    parameter int SPUR_CYCLES  = SPUR_CYC
) (
    // Clock; rst is the supply lockout.
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // Monitors and channel diagnostics.
    input  wire ddsl_mon_type  mon,
    input  wire ddsl_chan_type chan,
    input  wire logic          output_kill_pin,
    input  wire logic          link_fault_in,
    // Straps.
    input  wire logic          sel_strap,
    input  wire logic          mode_strap_hi,
    input  wire logic          mode_strap_lo,
    // Outputs.
    output logic [NCH-1:0]     drive_en,
    output logic [2:0]         indicator_row,
    output logic [2:0]         indicator_column,
    output logic [NCH-1:0]     indicator_link,
    output logic               fault_n,
    output logic               host_data_oe_n,
    output logic               cfg_done,
    // AXI4-Lite slave.
    input  wire logic [7:0]    s_awaddr,
    input  wire logic          s_awvalid,
    output logic               s_awready,
    input  wire logic [31:0]   s_wdata,
    input  wire logic [3:0]    s_wstrb,
    input  wire logic          s_wvalid,
    output logic               s_wready,
    output logic [1:0]         s_bresp,
    output logic               s_bvalid,
    input  wire logic          s_bready,
    input  wire logic [7:0]    s_araddr,
    input  wire logic          s_arvalid,
    output logic               s_arready,
    output logic [31:0]        s_rdata,
    output logic [1:0]         s_rresp,
    output logic               s_rvalid,
    input  wire logic          s_rready
);
    ddsl_state_type  state, next_state;
    logic [NCH-1:0]  out_cmd, next_out_cmd;
    logic [4:0]      gfault, next_gfault;
    logic            lfault, next_lfault;
    logic [2:0]      straps, next_straps;
    logic            mon_low, next_mon_low, mon_miss, next_mon_miss;
    logic [31:0]     blank_cnt, next_blank_cnt;
    logic [31:0]     blank_cnt2, next_blank_cnt2;
    logic [31:0]     hold_cnt [NCH];
    logic [31:0]     next_hold_cnt [NCH];
    logic [NCH-1:0]  ind_gate;
    logic [NCH-1:0]  short_rep, oloff_rep, next_oloff_rep;
    logic [NCH-1:0]  short_q, next_short_q;
    logic [31:0]     spur_cnt [NCH];
    logic [31:0]     next_spur_cnt [NCH];
    logic [NCH-1:0]  drv_q, next_drv_q;
    logic [31:0]     row_cnt, next_row_cnt;
    logic [1:0]      row, next_row;
    logic            aw_have, next_aw_have, w_have, next_w_have;
    logic [7:0]      aw_addr, next_aw_addr;
    logic [31:0]     w_data, next_w_data;
    logic [3:0]      w_strb, next_w_strb;
    logic            bvalid, next_bvalid;
    logic [1:0]      bresp, next_bresp;
    logic            rvalid, next_rvalid;
    logic [1:0]      rresp, next_rresp;
    logic [31:0]     rdata, next_rdata;
    logic [NCH-1:0]  ind_state;

    // A hot channel is off until its thermal flag drops,
    // which restarts it after cooling.
    assign drive_en = (state == DDSL_RUN && !output_kill_pin) ?
                      (out_cmd & ~chan.thermal) : '0;
    // Supply flags switch no output off.

    // Gate low while hold-off runs.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ind_gate[i] = (hold_cnt[i] == ZERO32);
            if (chan.thermal[i] || chan.current_limit[i]) begin
                next_hold_cnt[i] = 32'(HOLD_CYCLES);
            end else if (hold_cnt[i] != ZERO32) begin
                next_hold_cnt[i] = hold_cnt[i] - 32'h1;
            end else begin
                next_hold_cnt[i] = ZERO32;
            end
        end
    end

    assign ind_state = drive_en & ind_gate & ~chan.thermal & ~chan.current_limit;

    // A short masks open-load-off; short and open-load-on
    // pass straight through at any rate.
    assign short_rep = chan.short_raw;
    always_comb begin
        next_short_q = chan.short_raw;
        next_drv_q   = drive_en;
        for (int i = 0; i < NCH; i++) begin
            next_oloff_rep[i] = chan.open_off_raw[i] & ~chan.short_raw[i];
            // The spur timer loads when a short clears and is zeroed
            // on a switching edge; oloff_rep does not use it.
            if (short_q[i] && !chan.short_raw[i]) begin
                next_spur_cnt[i] = 32'(SPUR_CYCLES);
            end else if (drv_q[i] != drive_en[i]) begin
                next_spur_cnt[i] = ZERO32;
            end else if (spur_cnt[i] != ZERO32) begin
                next_spur_cnt[i] = spur_cnt[i] - 32'h1;
            end else begin
                next_spur_cnt[i] = ZERO32;
            end
        end
    end
    assign oloff_rep = next_oloff_rep;
    // Software masks the spurious window.

    // A comparator change must last the whole blank window.
    always_comb begin
        next_mon_low    = mon_low;
        next_mon_miss   = mon_miss;
        next_blank_cnt  = ZERO32;
        next_blank_cnt2 = ZERO32;
        if (mon.low_supply != mon_low) begin
            next_blank_cnt = blank_cnt + 32'h1;
            if (blank_cnt >= 32'(BLANK_CYCLES - 1)) begin
                next_mon_low   = mon.low_supply;
                next_blank_cnt = ZERO32;
            end
        end
        if (mon.supply_missing != mon_miss) begin
            next_blank_cnt2 = blank_cnt2 + 32'h1;
            if (blank_cnt2 >= 32'(BLANK_CYCLES - 1)) begin
                next_mon_miss   = mon.supply_missing;
                next_blank_cnt2 = ZERO32;
            end
        end
    end

    // Straps are caught on the first clock after lockout.
    always_comb begin
        next_state  = state;
        next_straps = straps;
        case (state)
            DDSL_LOCK: begin
                next_straps = {sel_strap, mode_strap_hi, mode_strap_lo};
                next_state  = DDSL_CFG;
            end
            DDSL_CFG:  next_state = DDSL_RUN;
            DDSL_RUN:  next_state = DDSL_RUN;
            default:   next_state = DDSL_LOCK;
        endcase
    end
    assign host_data_oe_n = (state != DDSL_RUN);
    assign cfg_done       = (state == DDSL_RUN);

    // Rows advance 0,1,2 in turn.
    always_comb begin
        next_row_cnt = row_cnt + 32'h1;
        next_row     = row;
        if (row_cnt >= 32'(ROW_CYCLES - 1)) begin
            next_row_cnt = ZERO32;
            next_row     = (row == 2'h2) ? 2'h0 : row + 2'h1;
        end
    end
    always_comb begin
        indicator_row    = 3'h0;
        indicator_column = 3'h0;
        indicator_row[row] = 1'b1;
        for (int c = 0; c < 3; c++) begin
            if (int'(row) * 3 + c < NCH) begin
                indicator_column[c] = ind_state[int'(row) * 3 + c];
            end
        end
    end
    assign indicator_link = out_cmd & ind_gate;

    assign fault_n = ~(gfault[GF_LOW] | gfault[GF_MISS] | lfault);

    // AXI4-Lite slave.
    wire wr_fire = aw_have && w_have && !bvalid;
    wire rd_take = s_arvalid && !rvalid;
    wire rd_gf   = rd_take && s_araddr == ADDR_GLOBAL_FAULT;
    wire rd_lf   = rd_take && s_araddr == ADDR_LINK_FAULT;
    assign s_awready = !aw_have;
    assign s_wready  = !w_have;
    assign s_arready = !rvalid;
    assign s_bvalid  = bvalid;
    assign s_bresp   = bresp;
    assign s_rvalid  = rvalid;
    assign s_rresp   = rresp;
    assign s_rdata   = rdata;

    always_comb begin
        logic [4:0] ev;
        ev = 5'h0;
        ev[GF_LOW]  = mon_low;
        ev[GF_MISS] = mon_miss;
        ev[GF_OTP]  = mon.die_hot;
        ev[GF_OFF]  = (drive_en == '0);
        ev[GF_LAMP] = |chan.cold_lamp;
        next_aw_have = aw_have;
        next_w_have  = w_have;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_rdata   = rdata;
        next_out_cmd = out_cmd;
        // A live event wins over a read clear.
        next_gfault = (rd_gf ? 5'h0 : gfault) | ev;
        next_lfault = (rd_lf ? 1'b0 : lfault) | link_fault_in;
        if (s_awvalid && !aw_have) begin
            next_aw_have = 1'b1;
            next_aw_addr = s_awaddr;
        end
        if (s_wvalid && !w_have) begin
            next_w_have = 1'b1;
            next_w_data = s_wdata;
            next_w_strb = s_wstrb;
        end
        if (wr_fire) begin
            next_aw_have = 1'b0;
            next_w_have  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            if (aw_addr == ADDR_OUT_CMD) begin
                if (w_strb[0]) begin
                    next_out_cmd = w_data[NCH-1:0];
                end
            end else begin
                next_bresp = RESP_SLVERR;
            end
        end else if (bvalid && s_bready) begin
            next_bvalid = 1'b0;
        end
        if (rd_take) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            case (s_araddr)
                ADDR_OUT_CMD:      next_rdata = {24'h0, out_cmd};
                ADDR_GLOBAL_FAULT: next_rdata = {27'h0, gfault};
                ADDR_LINK_FAULT:   next_rdata = {31'h0, lfault};
                ADDR_CH_STATUS:    next_rdata = {24'h0, ind_gate};
                ADDR_STRAPS:       next_rdata = {29'h0, straps};
                ADDR_DIAG_RAW:     next_rdata = {16'h0, chan.open_on_raw, chan.thermal};
                ADDR_DIAG_SC:      next_rdata = {24'h0, short_rep};
                ADDR_DIAG_OLOFF:   next_rdata = {24'h0, oloff_rep};
                default: begin
                    next_rdata = ZERO32;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid && s_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // Lockout resets all; supply and link flags read high.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state      <= DDSL_LOCK;
            out_cmd    <= '0;
            gfault     <= 5'h03;
            lfault     <= 1'b1;
            straps     <= 3'h0;
            mon_low    <= 1'b1;
            mon_miss   <= 1'b1;
            blank_cnt  <= ZERO32;
            blank_cnt2 <= ZERO32;
            short_q    <= '0;
            drv_q      <= '0;
            row_cnt    <= ZERO32;
            row        <= 2'h0;
            aw_have    <= 1'b0;
            w_have     <= 1'b0;
            aw_addr    <= 8'h00;
            w_data     <= ZERO32;
            w_strb     <= 4'h0;
            bvalid     <= 1'b0;
            bresp      <= RESP_OKAY;
            rvalid     <= 1'b0;
            rresp      <= RESP_OKAY;
            rdata      <= ZERO32;
            for (int i = 0; i < NCH; i++) begin
                hold_cnt[i] <= ZERO32;
                spur_cnt[i] <= ZERO32;
            end
        end else begin
            state      <= next_state;
            out_cmd    <= next_out_cmd;
            gfault     <= next_gfault;
            lfault     <= next_lfault;
            straps     <= next_straps;
            mon_low    <= next_mon_low;
            mon_miss   <= next_mon_miss;
            blank_cnt  <= next_blank_cnt;
            blank_cnt2 <= next_blank_cnt2;
            short_q    <= next_short_q;
            drv_q      <= next_drv_q;
            row_cnt    <= next_row_cnt;
            row        <= next_row;
            aw_have    <= next_aw_have;
            w_have     <= next_w_have;
            aw_addr    <= next_aw_addr;
            w_data     <= next_w_data;
            w_strb     <= next_w_strb;
            bvalid     <= next_bvalid;
            bresp      <= next_bresp;
            rvalid     <= next_rvalid;
            rresp      <= next_rresp;
            rdata      <= next_rdata;
            for (int i = 0; i < NCH; i++) begin
                hold_cnt[i] <= next_hold_cnt[i];
                spur_cnt[i] <= next_spur_cnt[i];
            end
        end
    end
endmodule : ddsl_top

// ---- testbench/ddsl_host.sv ----
`timescale 1ns/10ps
module ddsl_host
    import ddsl_pkg::*;
#(
    parameter int SPUR_CYCLES = 10
) (
    // Clock.
    input  wire logic        sys_clk,
    // Write channels.
    output logic [7:0]       s_awaddr,
    output logic             s_awvalid,
    input  wire logic        s_awready,
    output logic [31:0]      s_wdata,
    output logic [3:0]       s_wstrb,
    output logic             s_wvalid,
    input  wire logic        s_wready,
    input  wire logic [1:0]  s_bresp,
    input  wire logic        s_bvalid,
    output logic             s_bready,
    // Read channels.
    output logic [7:0]       s_araddr,
    output logic             s_arvalid,
    input  wire logic        s_arready,
    input  wire logic [31:0] s_rdata,
    input  wire logic [1:0]  s_rresp,
    input  wire logic        s_rvalid,
    output logic             s_rready
);
    initial begin
        s_awaddr  = 8'h00;
        s_awvalid = 1'h0;
        s_wdata   = 32'h0000_0000;
        s_wstrb   = 4'h0;
        s_wvalid  = 1'h0;
        s_bready  = 1'h1;
        s_araddr  = 8'h00;
        s_arvalid = 1'h0;
        s_rready  = 1'h1;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, done;
        s_awaddr  <= a;
        s_wdata   <= d;
        s_wstrb   <= 4'hF;
        s_awvalid <= 1'h1;
        s_wvalid  <= 1'h1;
        do begin
            @(negedge sys_clk);
            ta   = s_awvalid && s_awready;
            tw   = s_wvalid && s_wready;
            done = s_bvalid;
            r    = s_bresp;
            @(posedge sys_clk);
            if (ta) s_awvalid <= 1'h0;
            if (tw) s_wvalid <= 1'h0;
        end while (!done);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, done;
        s_araddr  <= a;
        s_arvalid <= 1'h1;
        do begin
            @(negedge sys_clk);
            ta   = s_arvalid && s_arready;
            done = s_rvalid;
            d    = s_rdata;
            r    = s_rresp;
            @(posedge sys_clk);
            if (ta) s_arvalid <= 1'h0;
        end while (!done);
    endtask : rd

    // Reading both frees the fault pin.
    task automatic clear_fault();
        logic [31:0] d;
        logic [1:0]  r;
        rd(ADDR_GLOBAL_FAULT, d, r);
        rd(ADDR_LINK_FAULT, d, r);
    endtask : clear_fault

    task automatic spur_wait();
        repeat (SPUR_CYCLES) @(posedge sys_clk);
    endtask : spur_wait
endmodule : ddsl_host

// ---- testbench/ddsl_top_sva.sv ----
`timescale 1ns/10ps
module ddsl_chk
    import ddsl_pkg::*;
#(
    parameter int BLANK_CYCLES = 8,
    parameter int ROW_CYCLES   = 4
) (
    // Clock and reset.
    input wire logic           sys_clk,
    input wire logic           rst,
    // Inputs.
    input wire ddsl_mon_type   mon,
    input wire ddsl_chan_type  chan,
    input wire logic           output_kill_pin,
    input wire logic           link_fault_in,
    // Outputs.
    input wire logic [NCH-1:0] drive_en,
    input wire logic [2:0]     indicator_row,
    input wire logic [NCH-1:0] indicator_link,
    input wire logic           fault_n,
    input wire logic           host_data_oe_n,
    input wire logic           cfg_done
);
    logic [2:0]  prev_row;
    logic [2:0]  next_prev_row;
    logic [15:0] row_age;
    logic [15:0] next_row_age;
    logic [15:0] low_age;
    logic [15:0] next_low_age;
    logic        armed;
    logic        next_armed;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    always_comb begin
        next_prev_row = indicator_row;
        next_armed    = armed | (indicator_row != prev_row);
        next_row_age  = (indicator_row != prev_row) ? 16'h0000 : row_age + 16'h0001;
        next_low_age  = mon.low_supply ? low_age + 16'h0001 : 16'h0000;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev_row <= 3'h1;
            armed    <= 1'h0;
            row_age  <= 16'h0000;
            low_age  <= 16'h0000;
        end else begin
            prev_row <= next_prev_row;
            armed    <= next_armed;
            row_age  <= next_row_age;
            low_age  <= next_low_age;
        end
    end

    reset_state_a:
        assert property ($fell(rst) |-> !fault_n && drive_en == 8'h00 && host_data_oe_n)
        else $error("Lockout outputs wrong.");
    config_release_a:
        assert property ($fell(rst) |-> host_data_oe_n ##[1:3] (cfg_done && !host_data_oe_n))
        else $error("Data pins not released.");
    link_fault_pin_a:
        assert property (link_fault_in |-> ##[1:4] !fault_n)
        else $error("Link fault not on pin.");
    low_supply_flag_a:
        assert property (low_age > 16'(BLANK_CYCLES + 3) |-> !fault_n)
        else $error("Low supply not on pin.");
    supply_blanking_a:
        assert property ($rose(mon.low_supply) && fault_n && !link_fault_in
                         && !mon.supply_missing |-> fault_n [*4])
        else $error("Blanking too short.");
    kill_drives_off_a:
        assert property (output_kill_pin |-> drive_en == 8'h00)
        else $error("Drive while killed.");
    thermal_off_a:
        assert property (|chan.thermal |-> (drive_en & chan.thermal) == 8'h00)
        else $error("Hot channel driven.");
    row_order_a:
        assert property (indicator_row != prev_row |->
                         $onehot(indicator_row) && indicator_row == {prev_row[1:0], prev_row[2]})
        else $error("Row order wrong.");
    row_period_a:
        assert property (indicator_row != prev_row && armed |-> row_age == 16'(ROW_CYCLES - 1))
        else $error("Row length wrong.");
    gate_hold_a:
        assert property ($fell(chan.current_limit[0]) |-> !indicator_link[0] [*8])
        else $error("Indicator relit early.");

    cover property ($rose(fault_n));
    cover property (output_kill_pin && cfg_done);
    cover property ($rose(indicator_row[0]));
endmodule : ddsl_chk

bind ddsl_top ddsl_chk #(.BLANK_CYCLES(BLANK_CYCLES), .ROW_CYCLES(ROW_CYCLES)) ddsl_chk_inst (
    .sys_clk(sys_clk), .rst(rst), .mon(mon), .chan(chan),
    .output_kill_pin(output_kill_pin), .link_fault_in(link_fault_in),
    .drive_en(drive_en), .indicator_row(indicator_row), .indicator_link(indicator_link),
    .fault_n(fault_n), .host_data_oe_n(host_data_oe_n), .cfg_done(cfg_done)
);

// ---- testbench/driver_diag_status_led_tb.sv ----
`timescale 1ns/10ps
module driver_diag_status_led_tb
    import ddsl_pkg::*;
;
    localparam int BLANK = 8;
    localparam int HOLD  = 20;
    localparam int SPUR  = 10;
    logic          sys_clk = 1'h0;
    logic          rst, output_kill_pin, link_fault_in, sel_strap, mode_strap_hi, mode_strap_lo;
    ddsl_mon_type  mon;
    ddsl_chan_type chan;
    logic [7:0]    drive_en, indicator_link, s_awaddr, s_araddr;
    logic [2:0]    indicator_row, indicator_column;
    logic          fault_n, host_data_oe_n, cfg_done, s_awvalid, s_awready, s_wvalid, s_wready;
    logic          s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
    logic [31:0]   s_wdata, s_rdata, rd_data;
    logic [3:0]    s_wstrb;
    logic [1:0]    s_bresp, s_rresp, resp;
    int            err_count = 0;
    int            cmp_count = 0;
    int            cyc = 0;
    logic [31:0]   flag_tab [6] = '{32'h01, 32'h02, 32'h04, 32'h08, 32'h10, 32'h00};
    logic [31:0]   drv_tab [6] = '{32'hA5, 32'hA5, 32'hA5, 32'h00, 32'hA5, 32'hA5};
    logic [31:0]   flt_tab [6] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h1, 32'h0};

    ddsl_top #(.BLANK_CYCLES(BLANK), .HOLD_CYCLES(HOLD), .ROW_CYCLES(4), .SPUR_CYCLES(SPUR))
    ddsl_top_inst (
        .sys_clk(sys_clk), .rst(rst), .mon(mon), .chan(chan), .output_kill_pin(output_kill_pin),
        .link_fault_in(link_fault_in), .sel_strap(sel_strap), .mode_strap_hi(mode_strap_hi),
        .mode_strap_lo(mode_strap_lo), .drive_en(drive_en), .indicator_row(indicator_row),
        .indicator_column(indicator_column), .indicator_link(indicator_link),
        .fault_n(fault_n), .host_data_oe_n(host_data_oe_n), .cfg_done(cfg_done),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready)
    );

    ddsl_host #(.SPUR_CYCLES(SPUR)) ddsl_host_inst (
        .sys_clk(sys_clk), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready)
    );

    always #5 sys_clk = ~sys_clk;

    task automatic test_done();
        if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        ddsl_host_inst.rd(a, rd_data, resp);
        chk("read resp", {30'h0, RESP_OKAY}, {30'h0, resp});
        chk("read data", exp, rd_data);
    endtask : rdc

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : step

    task automatic set_cond(input int i, input logic v);
        case (i)
            0: mon.low_supply <= v;
            1: mon.supply_missing <= v;
            2: mon.die_hot <= v;
            3: output_kill_pin <= v;
            4: chan.cold_lamp[3] <= v;
            default: link_fault_in <= v;
        endcase
    endtask : set_cond

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        rst = 1'h1;
        mon = '0;
        chan = '0;
        output_kill_pin = 1'h0;
        link_fault_in = 1'h0;
        sel_strap = 1'h1;
        mode_strap_hi = 1'h0;
        mode_strap_lo = 1'h1;
        step(16);
        rst <= 1'h0;
        step(20);
        rdc(ADDR_STRAPS, 32'h5);
        rdc(ADDR_GLOBAL_FAULT, 32'hB);
        rdc(ADDR_LINK_FAULT, 32'h1);
        ddsl_host_inst.wr(ADDR_OUT_CMD, 32'hA5, resp);
        rdc(ADDR_OUT_CMD, 32'hA5);
        rdc(ADDR_GLOBAL_FAULT, 32'h8);
        rdc(ADDR_GLOBAL_FAULT, 32'h0);
        @(negedge sys_clk);
        chk("fault pin", 32'h1, {31'h0, fault_n});
        chk("indicator", 32'hA5, {24'h0, indicator_link});
        @(posedge sys_clk);
        mon.low_supply <= 1'h1;
        step(3);
        mon.low_supply <= 1'h0;
        step(BLANK + 4);
        rdc(ADDR_GLOBAL_FAULT, 32'h0);
        for (int i = 0; i < 6; i++) begin
            set_cond(i, 1'h1);
            step(BLANK + 6);
            @(negedge sys_clk);
            chk("drive", drv_tab[i], {24'h0, drive_en});
            chk("fault pin", flt_tab[i], {31'h0, fault_n});
            @(posedge sys_clk);
            rdc(ADDR_GLOBAL_FAULT, flag_tab[i]);
            rdc(ADDR_LINK_FAULT, {31'h0, (i == 5)});
            set_cond(i, 1'h0);
            step(BLANK + 6);
            ddsl_host_inst.clear_fault();
            rdc(ADDR_GLOBAL_FAULT, 32'h0);
        end
        ddsl_host_inst.rd(8'h40, rd_data, resp);
        chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, resp});
        chk("unmapped data", ZERO32, rd_data);
        ddsl_host_inst.wr(8'h40, 32'hFF, resp);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
        ddsl_host_inst.wr(ADDR_GLOBAL_FAULT, 32'hFF, resp);
        rdc(ADDR_GLOBAL_FAULT, 32'h0);
        for (int j = 0; j < 2; j++) begin
            if (j == 0) chan.thermal[0] <= 1'h1;
            else chan.current_limit[0] <= 1'h1;
            step(4);
            @(negedge sys_clk);
            chk("drive", (j == 0) ? 32'hA4 : 32'hA5, {24'h0, drive_en});
            chk("indicator", 32'hA4, {24'h0, indicator_link});
            @(posedge sys_clk);
            chan.thermal[0] <= 1'h0;
            chan.current_limit[0] <= 1'h0;
            step(HOLD / 2);
            @(negedge sys_clk);
            chk("drive", 32'hA5, {24'h0, drive_en});
            chk("indicator", 32'hA4, {24'h0, indicator_link});
            step(HOLD + 4);
            @(negedge sys_clk);
            chk("indicator", 32'hA5, {24'h0, indicator_link});
            @(posedge sys_clk);
        end
        chan.short_raw <= 8'h04;
        chan.open_off_raw <= 8'h24;
        chan.open_on_raw <= 8'h04;
        step(6);
        rdc(ADDR_DIAG_SC, 32'h04);
        rdc(ADDR_DIAG_OLOFF, 32'h20);
        rdc(ADDR_DIAG_RAW, 32'h0400);
        chan.short_raw <= 8'h00;
        ddsl_host_inst.spur_wait();
        rdc(ADDR_DIAG_OLOFF, 32'h24);
        rst <= 1'h1;
        step(2);
        @(negedge sys_clk);
        chk("fault pin", 32'h0, {31'h0, fault_n});
        chk("drive", 32'h0, {24'h0, drive_en});
        chk("data pins", 32'h1, {31'h0, host_data_oe_n});
        @(posedge sys_clk);
        rst <= 1'h0;
        step(6);
        rdc(ADDR_STRAPS, 32'h5);
        rdc(ADDR_GLOBAL_FAULT, 32'hB);
        test_done();
    end
endmodule : driver_diag_status_led_tb
